// *** spm_top.sv ***
// serial peripheral port with classic wishbone register slave
`timescale 1ns/1ns
`default_nettype none
`include "spm_consts.svh"

module spm_top
  import spm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  output logic i2c_en_o
);

  spm_state_t s_q;
  spm_state_t s_d;
  spm_pins_t pin_s;
  logic req;
  logic wr;
  logic rd;
  logic [9:0] idx;
  logic [7:0] wd;
  logic busy;
  logic done;
  logic sclk_edge;

  // ==========================================================
  // pin synchronisers; every pin from the far side is asynchronous
  spm_sync u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .pin('{ss_n: ss_n_i, miso: miso_i, mosi: mosi_i, sclk: sclk_i}),
    .pin_s(pin_s)
  );

  // ==========================================================
  // one serial clock edge: sample or launch depending on phase
  function automatic spm_state_t step(input spm_state_t st, input logic rxb);
    logic lead;
    logic samp;
    begin
      lead = ~st.edge_n[0];
      samp = lead ^ st.cpha;
      if (samp)
      begin
        st.sh[0] = rxb;
      end
      else if (st.cpha || st.edge_n != `SPM_LAST_EDGE)
      begin
        // phase zero has no launch on the final trailing edge
        st.dout = st.sh[7];
        st.sh = {st.sh[6:0], 1'b0};
      end
      st.edge_n = st.edge_n + 4'h1;
      step = st;
    end
  endfunction

  // ==========================================================
  // bus decode: classic single cycle, ack one cycle after strobe
  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign idx = wb_adr_i[11:2];
  assign wd = wb_dat_i[7:0];
  assign sclk_edge = pin_s.sclk ^ s_q.sclk_prev;

  // a transfer counts as running mid-burst in either mode
  always_comb
  begin
    if (s_q.mstr)
    begin
      busy = s_q.mode == SPM_SHIFT;
    end
    else
    begin
      busy = s_q.edge_n != 4'h0 || s_q.got16;
    end
  end

  // ==========================================================
  // next state: software first, hardware events last so sets win
  always_comb
  begin
    s_d = s_q;
    done = 1'b0;
    s_d.ack = req;
    s_d.rdat = 8'h00;
    s_d.sclk_prev = pin_s.sclk;

    // register reads; unmapped addresses read zero
    if (rd)
    begin
      case (idx)
        `SPM_IDX_DATA:
        begin
          s_d.rdat = s_q.rx;
          s_d.xfer_done = 1'b0;
        end
        `SPM_IDX_CTRL:
        begin
          s_d.rdat = {s_q.xfer_done, s_q.coll, s_q.pen, s_q.mstr, s_q.cpol, s_q.cpha,
                      s_q.rate[1], s_q.mstr ? s_q.rate[0] : pin_s.ss_n};
        end
        `SPM_IDX_ISTS:
        begin
          s_d.rdat = {6'h00, s_q.sts};
        end
        `SPM_IDX_IEN:
        begin
          s_d.rdat = {6'h00, s_q.ien};
        end
        `SPM_IDX_CFG:
        begin
          s_d.rdat = {7'h00, s_q.alt};
        end
        default:
        begin
          s_d.rdat = 8'h00;
        end
      endcase
    end

    // register writes
    if (wr)
    begin
      case (idx)
        `SPM_IDX_DATA:
        begin
          if (busy)
          begin
            s_d.coll = 1'b1;
            s_d.sts[`SPM_INT_COLL] = 1'b1;
          end
          else if (s_q.pen)
          begin
            // phase zero shows the msb before the first edge
            s_d.sh = s_q.cpha ? wd : {wd[6:0], 1'b0};
            s_d.dout = s_q.cpha ? s_q.dout : wd[7];
            if (s_q.mstr)
            begin
              s_d.mode = SPM_SHIFT;
              s_d.edge_n = 4'h0;
              s_d.div = 4'((5'h01 << s_q.rate) - 5'h01);
            end
          end
        end
        `SPM_IDX_CTRL:
        begin
          // flags clear on a zero, a one leaves them alone
          s_d.xfer_done = s_q.xfer_done & wd[`SPM_BIT_DONE];
          s_d.coll = s_q.coll & wd[`SPM_BIT_COLL];
          s_d.pen = wd[`SPM_BIT_PEN];
          s_d.mstr = wd[`SPM_BIT_MSTR];
          s_d.cpol = wd[`SPM_BIT_CPOL];
          s_d.cpha = wd[`SPM_BIT_CPHA];
          s_d.rate = {wd[`SPM_BIT_RHI], wd[`SPM_BIT_RLO]};
        end
        `SPM_IDX_ICLR:
        begin
          s_d.sts = s_q.sts & ~wd[1:0];
        end
        `SPM_IDX_IEN:
        begin
          s_d.ien = wd[1:0];
        end
        `SPM_IDX_CFG:
        begin
          s_d.alt = wd[`SPM_CFG_ALT];
        end
        default:
        begin
          s_d.ien = s_d.ien;
        end
      endcase
    end

    // serial engine
    if (!s_q.pen)
    begin
      s_d.mode = SPM_IDLE;
      s_d.edge_n = 4'h0;
      s_d.got16 = 1'b0;
      s_d.sclk = s_d.cpol;
    end
    else if (s_q.mstr)
    begin
      case (s_q.mode)
        SPM_SHIFT:
        begin
          if (s_q.div == 4'h0)
          begin
            // half period of 2^rate cycles: fosc/2,4,8,16
            s_d.div = 4'((5'h01 << s_q.rate) - 5'h01);
            s_d.sclk = ~s_q.sclk;
            s_d = step(s_d, pin_s.miso);
            if (s_q.edge_n == `SPM_LAST_EDGE)
            begin
              s_d.mode = SPM_IDLE;
              done = 1'b1;
            end
          end
          else
          begin
            s_d.div = s_q.div - 4'h1;
          end
        end
        default:
        begin
          // new polarity shows at once, so enabling makes no false edge
          s_d.sclk = s_d.cpol;
        end
      endcase
    end
    else
    begin
      // slave: clock comes in, edges count only while selected
      s_d.mode = SPM_IDLE;
      s_d.sclk = s_d.cpol;
      if (pin_s.ss_n)
      begin
        s_d.edge_n = 4'h0;
        s_d.got16 = 1'b0;
        if (s_q.got16)
        begin
          done = 1'b1;
        end
      end
      else if (sclk_edge)
      begin
        s_d = step(s_d, pin_s.mosi);
        if (s_q.edge_n == `SPM_LAST_EDGE)
        begin
          if (s_q.cpha)
          begin
            done = 1'b1;
          end
          else
          begin
            s_d.got16 = 1'b1;
          end
        end
      end
    end

    // completion: latch received byte and raise the flags
    if (done)
    begin
      s_d.rx = s_d.sh;
      s_d.xfer_done = 1'b1;
      s_d.sts[`SPM_INT_DONE] = 1'b1;
    end

    // pin enables and the shared-pin arbitration
    s_d.sclk_oe = s_d.pen & s_d.mstr;
    s_d.mosi_oe = s_d.pen & s_d.mstr;
    s_d.miso_oe = s_d.pen & ~s_d.mstr & ~pin_s.ss_n;
    s_d.i2c_en = ~s_d.pen | s_d.alt;
    s_d.irq = |(s_d.sts & s_d.ien);
  end

  // ==========================================================
  // state register; clock enable low freezes everything
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.cpha <= 1'b1;
      s_q.i2c_en <= 1'b1;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign wb_dat_o = {24'h000000, s_q.rdat};
  assign wb_ack_o = s_q.ack;
  assign irq_o = s_q.irq;
  assign sclk_o = s_q.sclk;
  assign sclk_oe = s_q.sclk_oe;
  assign mosi_o = s_q.dout;
  assign mosi_oe = s_q.mosi_oe;
  assign miso_o = s_q.dout;
  assign miso_oe = s_q.miso_oe;
  assign i2c_en_o = s_q.i2c_en;

endmodule
`default_nettype wire

// *** spm_consts.svh ***
// constants for the serial peripheral port: offsets, fields, resets
// Function
// - set done flag when each byte finishes
// - done flag cleared by write or data read
// - data write mid-transfer sets collision flag
// - relocated pins auto-enable the two-wire interface
// - master select one drives serial clock out
// - master select zero takes serial clock in
// - polarity bit sets serial clock idle level
// - phase bit picks leading or trailing launch
// - rate bits divide clock by 2/4/8/16
// - slave read of rate_lo returns select pin
// - data write loads byte to transmit
// - data read returns last received byte
// - master write starts eight clock burst
// - msb first, one bit each way per clock
// - slave latches byte per phase rule
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// ==========================================================
// register indices (byte address = 4 * index)
`define SPM_IDX_DATA 10'h0F7
`define SPM_IDX_CTRL 10'h0F8
`define SPM_IDX_ISTS 10'h0F9
`define SPM_IDX_ICLR 10'h0FA
`define SPM_IDX_IEN 10'h0FB
`define SPM_IDX_CFG 10'h0FC

// ==========================================================
// control register fields
`define SPM_BIT_DONE 7
`define SPM_BIT_COLL 6
`define SPM_BIT_PEN 5
`define SPM_BIT_MSTR 4
`define SPM_BIT_CPOL 3
`define SPM_BIT_CPHA 2
`define SPM_BIT_RHI 1
`define SPM_BIT_RLO 0
`define SPM_CTRL_RST 8'h04
`define SPM_DATA_RST 8'h00

// ==========================================================
// interrupt bits, config bit, timing
`define SPM_INT_DONE 0
`define SPM_INT_COLL 1
`define SPM_CFG_ALT 0
`define SPM_LAST_EDGE 4'hF
`define SPM_PIN_RST 4'h8

`endif

// *** spm_pkg.sv ***
// types shared by the serial peripheral port modules
package spm_pkg;

  // ==========================================================
  // master shift sequencer
  typedef enum logic {SPM_IDLE, SPM_SHIFT} spm_mode_t;

  // ==========================================================
  // synchronised pins: {ss_n, miso, mosi, sclk}
  typedef struct packed {
    logic ss_n;
    logic miso;
    logic mosi;
    logic sclk;
  } spm_pins_t;

  typedef struct packed {
    spm_pins_t s1;
    spm_pins_t s2;
    spm_pins_t s3;
    spm_pins_t out;
  } spm_sync_st_t;

  // ==========================================================
  // whole state of the port
  typedef struct packed {
    spm_mode_t mode;
    logic xfer_done;
    logic coll;
    logic pen;
    logic mstr;
    logic cpol;
    logic cpha;
    logic [1:0] rate;
    logic alt;
    logic [7:0] rx;
    logic [7:0] sh;
    logic dout;
    logic sclk;
    logic [3:0] edge_n;
    logic [3:0] div;
    logic got16;
    logic sclk_prev;
    logic [1:0] sts;
    logic [1:0] ien;
    logic ack;
    logic [7:0] rdat;
    logic irq;
    logic sclk_oe;
    logic mosi_oe;
    logic miso_oe;
    logic i2c_en;
  } spm_state_t;

endpackage

// *** spm_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
`include "spm_consts.svh"

module spm_sync
  import spm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire spm_pins_t pin,
  output spm_pins_t pin_s
);

  spm_sync_st_t s_q;
  spm_sync_st_t s_d;

  // ==========================================================
  // next state: a bit moves only once stages two and three agree
  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.out = ((s_q.s2 ^ s_q.s3) & s_q.out) | (~(s_q.s2 ^ s_q.s3) & s_q.s3);
  end

  // ==========================================================
  // state register; select idles high out of reset
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_q <= {`SPM_PIN_RST, `SPM_PIN_RST, `SPM_PIN_RST, `SPM_PIN_RST};
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign pin_s = s_q.out;

endmodule
`default_nettype wire

// *** spm_assertions.sv ***
// checker for bus and pin outputs of the serial port
`timescale 1ns/1ns
`default_nettype none
module spm_assertions (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic sclk_oe,
  input wire logic mosi_o,
  input wire logic mosi_oe,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // ==========================================================
  // one clock domain; reset silences every check
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_ack_req; ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_ack_src; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_src: assert property (p_ack_src) else $error("stray ack");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data off ack");
  property p_oe_mstr; mosi_oe == sclk_oe; endproperty
  a_oe_mstr: assert property (p_oe_mstr) else $error("master enables");
  property p_oe_excl; miso_oe |-> !sclk_oe; endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("slave drives clock");
  property p_launch; mosi_o == miso_o; endproperty
  a_launch: assert property (p_launch) else $error("launch flops differ");
  // a level drop needs a register write just before
  property p_irq_fall;
    $fell(irq_o) |-> (wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule
bind spm_top spm_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o), .sclk_oe(sclk_oe), .mosi_o(mosi_o),
  .mosi_oe(mosi_oe), .miso_o(miso_o), .miso_oe(miso_oe));
`default_nettype wire

// *** spm_partner.sv ***
// far-end slave device model for master transfers
`timescale 1ns/1ns
`default_nettype none
module spm_partner (
  input wire logic clk_sys,
  input wire logic en,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [15:0] got,
  output logic got_v
);
  int n = 0;
  int k = 0;
  int gap = 0;
  logic prev = 1'b0;
  logic [7:0] rx = 8'h00;
  // phase 1 holds the msb until the second leading edge
  always_comb miso = tx[7 - ((k > cpha) ? k - cpha : 0)];
  // edges only count while the port drives the clock
  always @(posedge clk_sys)
  begin
    prev <= sclk;
    gap <= (en && sclk != prev) ? 1 : gap + 1;
    got_v <= en && sclk != prev && n == 15;
    if (!en)
    begin
      n <= 0;
      k <= 0;
    end
    else if (sclk != prev && n == 15)
    begin
      // last edge is trailing: it samples only in phase one
      n <= 0;
      k <= 0;
      got <= {gap[7:0], cpha ? {rx[6:0], mosi} : rx};
    end
    else if (sclk != prev)
    begin
      n <= n + 1;
      if ((prev == cpol) ^ cpha)
        rx <= {rx[6:0], mosi};
      else
        k <= k + 1;
    end
  end
endmodule
`default_nettype wire

// *** spi_master_slave_port_test.sv ***
// bench: register bus, master transfers, slave select, relocation
`timescale 1ns/1ns
`default_nettype none
`include "spm_consts.svh"
module spi_master_slave_port_test;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic ss_n = 1'b1;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic stog = 1'b0;
  logic smosi = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [7:0] wd = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [31:0] rdat;
  logic [15:0] got;
  logic ack, irq, sclk_o, sclk_oe, mosi_o, miso, got_v, miso_oe, i2c_en;
  wire logic sclk = sclk_oe ? sclk_o : (cpol ^ stog);
  int num_errors = 0;
  int checks = 0;
  logic [31:0] q_rd[$];
  logic [15:0] q_ser[$];
  // ==========================================================
  // design, far-end slave and clock
  spm_top DUT (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h0, wd}),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .sclk_i(sclk), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .mosi_i(smosi), .mosi_o(mosi_o), .mosi_oe(), .miso_i(miso),
    .miso_o(), .miso_oe(miso_oe), .ss_n_i(ss_n), .i2c_en_o(i2c_en));
  spm_partner u_far (.clk_sys(clk_sys), .en(sclk_oe), .sclk(sclk), .mosi(mosi_o),
    .cpol(cpol), .cpha(cpha), .tx(tx), .miso(miso), .got(got), .got_v(got_v));
  initial forever #10 clk_sys = ~clk_sys;
  // ==========================================================
  // checking and bus tasks
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic hang();
    cmp(32'h0, 32'h1);
    end_of_test();
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 600 && irq !== 1'b1; i++)
      @(posedge clk_sys);
    if (i == 600)
      hang();
  endtask
  // request held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wd <= d;
    for (i = 0; i < 50 && ack !== 1'b1; i++)
      @(posedge clk_sys);
    if (i == 50)
      hang();
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    q_rd.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  // results are paired with the oldest note as they appear
  always @(posedge clk_sys)
  begin
    if (ack === 1'b1 && we === 1'b0)
      cmp(rdat, q_rd.pop_front());
    if (got_v === 1'b1)
      cmp({16'h0, got}, q_ser.pop_front());
  end
  // ==========================================================
  // main sequence
  initial
  begin
    int m;
    int i;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
    void'($urandom(32'hBE047B76));
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(`SPM_IDX_CTRL, `SPM_CTRL_RST | 8'h01);
    rd(`SPM_IDX_DATA, `SPM_DATA_RST);
    rd(10'h100, 8'h00);
    cmp(i2c_en, 1'b1);
    wr(`SPM_IDX_IEN, 8'h03);
    // every polarity, phase and rate; received bytes only at slow rate
    for (m = 0; m < 16; m++)
    begin
      c = 8'h30 | 8'(m);
      d = 8'($urandom);
      wr(`SPM_IDX_CTRL, 8'h00);
      cpol <= m[3];
      cpha <= m[2];
      tx <= 8'($urandom);
      wr(`SPM_IDX_CTRL, c);
      q_ser.push_back({8'h01 << m[1:0], d});
      wr(`SPM_IDX_DATA, d);
      // collision status must not end the wait before the byte is done
      if (m == 15)
      begin
        wr(`SPM_IDX_IEN, 8'h01);
        wr(`SPM_IDX_DATA, ~d);
      end
      wait_irq();
      if (m[1:0] == 2'b11)
      begin
        rd(`SPM_IDX_DATA, tx);
        rd(`SPM_IDX_CTRL, c | (m == 15 ? 8'h40 : 8'h00));
      end
      else
      begin
        rd(`SPM_IDX_CTRL, c | 8'h80);
        wr(`SPM_IDX_CTRL, c);
        rd(`SPM_IDX_CTRL, c);
      end
      cmp(sclk_o, m[3]);
      wr(`SPM_IDX_IEN, 8'h00);
      rd(`SPM_IDX_ISTS, m == 15 ? 8'h03 : 8'h01);
      cmp(irq, 1'b0);
      wr(`SPM_IDX_ICLR, 8'h03);
      wr(`SPM_IDX_IEN, 8'h03);
      rd(`SPM_IDX_ISTS, 8'h00);
    end
    // slave: select level shows in the low rate bit
    cpol <= 1'b0;
    wr(`SPM_IDX_CTRL, 8'h24);
    for (m = 0; m < 2; m++)
    begin
      ss_n <= m[0];
      repeat (8) @(posedge clk_sys);
      rd(`SPM_IDX_CTRL, 8'h24 | 8'(m));
      cmp(miso_oe, !m[0]);
      cmp(sclk_oe, 1'b0);
    end
    // slave, phase zero: the bench is master and frames the byte
    d = 8'($urandom);
    c = 8'($urandom);
    tx <= c;
    wr(`SPM_IDX_CTRL, 8'h20);
    wr(`SPM_IDX_DATA, d);
    ss_n <= 1'b0;
    smosi <= c[7];
    for (i = 0; i < 8; i++)
    begin
      repeat (8) @(posedge clk_sys);
      e = {e[6:0], mosi_o};
      stog <= 1'b1;
      repeat (8) @(posedge clk_sys);
      c = {c[6:0], 1'b0};
      stog <= 1'b0;
      smosi <= c[7];
    end
    repeat (8) @(posedge clk_sys);
    ss_n <= 1'b1;
    wait_irq();
    cmp(e, d);
    rd(`SPM_IDX_CTRL, 8'hA1);
    rd(`SPM_IDX_DATA, tx);
    wr(`SPM_IDX_CFG, 8'h01);
    repeat (2) @(posedge clk_sys);
    cmp(i2c_en, 1'b1);
    wr(`SPM_IDX_CFG, 8'h00);
    repeat (2) @(posedge clk_sys);
    cmp(i2c_en, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
